// ===== design/slpt_lane_out.sv
/*
 output stage of one serial lane: power gate, test mux, polarity.
 assumes the lane data arrive already line coded.
*/
`timescale 1ns/1ps
module slpt_lane_out (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // controls
  input wire logic powerOn,
  input wire logic testOn,
  input wire logic flip,
  // data
  input wire logic seqBit,
  input wire logic laneIn,
  output logic laneOut
);
  logic next_laneOut;

  // test bits bypass the coder; a dark lane sends zero
  always_comb begin
    if (!powerOn) begin
      next_laneOut = 1'b0;
    end else if (testOn) begin
      next_laneOut = seqBit ^ flip;
    end else begin
      next_laneOut = laneIn ^ flip;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      laneOut <= 1'b0;
    end else begin
      laneOut <= next_laneOut;
    end
  end
endmodule

// ===== design/slpt_regs.sv
/*
 register bank of the serial lane side: sleep masks, lane test,
 reference select, temperature, emphasis, drive, lock alarms,
 reached over the serial programming port.
 assumes port pins and status inputs synchronous to clk.
*/
// Function
// R01: cleared soft bit sleeps function, enable high
// R02: pin mask bit keeps function always powered
// R03: bits 9,8 PLLs; bits 7..0 lanes
// R04: host sets pin mask, then drives enable
// R05: host holds enable, writes soft mask
// R06: upper byte inverts lane polarity
// R07: lower byte sends test sequence on lane
// R08: select code picks sequence length
// R09: test sequence sent without line coding
// R10: three-bit field sets full scale
// R11: temperature nine-bit signed, read only
// R12: emphasis on per lane, kind bit
// R13: four-bit drive level per lane
// R14: duty correction enable per lane
// R15: alarm bits report PLL lost lock
// R16: alarm register read only
// R17: sixteen-bit whole words, reserved ignored
`timescale 1ns/1ps
module slpt_regs #(
  parameter int LANES = 8,
  parameter int PLLS = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // serial programming port
  input wire logic portClk,
  input wire logic portSel_n,
  input wire logic portDataIn,
  output logic portDataOut,
  output logic portDataOutEn,
  // power control pin
  input wire logic enablePin,
  // status from the analog side
  input wire logic [8:0] dieTemp,
  input wire logic [PLLS-1:0] lockLost,
  // lane data
  input wire logic [LANES-1:0] laneIn,
  output logic [LANES-1:0] laneOut,
  // power controls
  output logic [LANES-1:0] lanePowerOn,
  output logic [PLLS-1:0] pllPowerOn,
  // analog settings
  output logic [2:0] refSelect,
  output logic [LANES-1:0] emphasisOn,
  output logic [LANES-1:0] emphasisKind,
  output logic [LANES-1:0] dutyFixOn,
  output logic [4*LANES-1:0] driveLevel
);
  // register storage
  logic [9:0] pinAssignedSleepMask;
  logic [15:0] softwareSleepMask;
  logic [15:0] laneTest;
  logic [15:0] patternRefSel;
  logic [15:0] emphasisA;
  logic [15:0] emphasisB;
  logic [15:0] driveA;
  logic [15:0] driveB;
  logic [8:0] tempCapture;
  logic [PLLS-1:0] lockAlarm;
  logic [9:0] next_pinAssignedSleepMask;
  logic [15:0] next_softwareSleepMask;
  logic [15:0] next_laneTest;
  logic [15:0] next_patternRefSel;
  logic [15:0] next_emphasisA;
  logic [15:0] next_emphasisB;
  logic [15:0] next_driveA;
  logic [15:0] next_driveB;
  // serial port state
  logic portClkPrev;
  logic [4:0] bitCount;
  logic [14:0] shiftIn;
  logic [7:0] header;
  logic [4:0] next_bitCount;
  logic [14:0] next_shiftIn;
  logic [7:0] next_header;
  logic next_portDataOut;
  logic next_portDataOutEn;
  logic riseEdge;
  logic fallEdge;
  logic writeStrobe;
  logic [6:0] writeAddr;
  logic [15:0] writeData;
  logic [15:0] readData;
  // power and test state
  logic [9:0] powerNow;
  logic [9:0] next_powerNow;
  logic [1:0] seqSelPrev;
  logic seqRestart;
  logic seqBit;

  // edges of the port clock, sampled as a plain input
  assign riseEdge = portClk & ~portClkPrev & ~portSel_n;
  assign fallEdge = ~portClk & portClkPrev & ~portSel_n;
  // whole word lands on the last rising edge of a write frame
  assign writeStrobe = riseEdge & (bitCount == slpt_pkg::FRAME_LAST) & ~header[7]; // R17
  assign writeAddr = header[6:0];
  assign writeData = {shiftIn, portDataIn};

  // frame counter, shifter, read-back driver
  always_comb begin
    next_bitCount = bitCount;
    next_shiftIn = shiftIn;
    next_header = header;
    next_portDataOut = portDataOut;
    next_portDataOutEn = portDataOutEn;
    if (portSel_n) begin
      next_bitCount = 5'h00;
      next_portDataOutEn = 1'b0;
      next_portDataOut = 1'b0;
    end else if (riseEdge) begin
      next_shiftIn = {shiftIn[13:0], portDataIn};
      if (bitCount == slpt_pkg::HDR_LAST) begin
        next_header = {shiftIn[6:0], portDataIn};
      end
      // extra clocks past a frame are ignored
      if (bitCount != slpt_pkg::FRAME_LAST + 5'h01) begin
        next_bitCount = bitCount + 5'h01;
      end
    end else if (fallEdge) begin
      if (header[7] && bitCount > slpt_pkg::HDR_LAST && bitCount <= slpt_pkg::FRAME_LAST) begin
        next_portDataOutEn = 1'b1;
        next_portDataOut = readData[4'(slpt_pkg::DATA_TOP - bitCount)]; // R17
      end else begin
        next_portDataOutEn = 1'b0;
        next_portDataOut = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      portClkPrev <= 1'b0;
      bitCount <= 5'h00;
      shiftIn <= 15'h0000;
      header <= 8'h00;
      portDataOut <= 1'b0;
      portDataOutEn <= 1'b0;
    end else begin
      portClkPrev <= portClk;
      bitCount <= next_bitCount;
      shiftIn <= next_shiftIn;
      header <= next_header;
      portDataOut <= next_portDataOut;
      portDataOutEn <= next_portDataOutEn;
    end
  end

  // read-back selection; unmapped offsets read zero
  always_comb begin
    if (writeAddr == slpt_pkg::ADDR_PIN_MASK) begin
      readData = {6'h00, pinAssignedSleepMask};
    end else if (writeAddr == slpt_pkg::ADDR_SW_MASK) begin
      readData = softwareSleepMask;
    end else if (writeAddr == slpt_pkg::ADDR_LANE_TEST) begin
      readData = laneTest;
    end else if (writeAddr == slpt_pkg::ADDR_SEL) begin
      readData = patternRefSel;
    end else if (writeAddr == slpt_pkg::ADDR_TEMP) begin
      readData = {7'h00, tempCapture}; // R11
    end else if (writeAddr == slpt_pkg::ADDR_EMPH_A) begin
      readData = emphasisA;
    end else if (writeAddr == slpt_pkg::ADDR_DRIVE_A) begin
      readData = driveA;
    end else if (writeAddr == slpt_pkg::ADDR_EMPH_B) begin
      readData = emphasisB;
    end else if (writeAddr == slpt_pkg::ADDR_DRIVE_B) begin
      readData = driveB;
    end else if (writeAddr == slpt_pkg::ADDR_ALARM) begin
      readData = {14'h0000, lockAlarm}; // R15
    end else begin
      readData = 16'h0000;
    end
  end

  // writable registers; reserved bits dropped on write
  always_comb begin
    next_pinAssignedSleepMask = pinAssignedSleepMask;
    next_softwareSleepMask = softwareSleepMask;
    next_laneTest = laneTest;
    next_patternRefSel = patternRefSel;
    next_emphasisA = emphasisA;
    next_emphasisB = emphasisB;
    next_driveA = driveA;
    next_driveB = driveB;
    // temperature and alarm offsets have no write path
    if (writeStrobe) begin // R16
      if (writeAddr == slpt_pkg::ADDR_PIN_MASK) begin
        next_pinAssignedSleepMask = writeData[9:0];
      end else if (writeAddr == slpt_pkg::ADDR_SW_MASK) begin
        next_softwareSleepMask = writeData;
      end else if (writeAddr == slpt_pkg::ADDR_LANE_TEST) begin
        next_laneTest = writeData;
      end else if (writeAddr == slpt_pkg::ADDR_SEL) begin
        next_patternRefSel = writeData & slpt_pkg::WMASK_SEL; // R17
      end else if (writeAddr == slpt_pkg::ADDR_EMPH_A) begin
        next_emphasisA = writeData & slpt_pkg::WMASK_EMPH;
      end else if (writeAddr == slpt_pkg::ADDR_DRIVE_A) begin
        next_driveA = writeData;
      end else if (writeAddr == slpt_pkg::ADDR_EMPH_B) begin
        next_emphasisB = writeData & slpt_pkg::WMASK_EMPH;
      end else if (writeAddr == slpt_pkg::ADDR_DRIVE_B) begin
        next_driveB = writeData;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pinAssignedSleepMask <= slpt_pkg::RST_PIN_MASK;
      softwareSleepMask <= slpt_pkg::RST_SW_MASK;
      laneTest <= slpt_pkg::RST_ZERO;
      patternRefSel <= slpt_pkg::RST_ZERO;
      emphasisA <= slpt_pkg::RST_ZERO;
      emphasisB <= slpt_pkg::RST_ZERO;
      driveA <= slpt_pkg::RST_ZERO;
      driveB <= slpt_pkg::RST_ZERO;
    end else begin
      pinAssignedSleepMask <= next_pinAssignedSleepMask;
      softwareSleepMask <= next_softwareSleepMask;
      laneTest <= next_laneTest;
      patternRefSel <= next_patternRefSel;
      emphasisA <= next_emphasisA;
      emphasisB <= next_emphasisB;
      driveA <= next_driveA;
      driveB <= next_driveB;
    end
  end

  // status capture; alarms follow the PLLs, host cannot touch them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tempCapture <= 9'h000;
      lockAlarm <= slpt_pkg::RST_ALARM;
    end else begin
      tempCapture <= dieTemp; // R11
      lockAlarm <= lockLost; // R15
    end
  end

  // pin mask holds a function on; else soft bit gated by enable
  always_comb begin
    next_powerNow = pinAssignedSleepMask | (softwareSleepMask[9:0] & {10{enablePin}}); // R01 R02 R03
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      powerNow <= slpt_pkg::RST_POWER;
    end else begin
      powerNow <= next_powerNow;
    end
  end

  assign lanePowerOn = powerNow[LANES-1:0]; // R03
  assign pllPowerOn = powerNow[slpt_pkg::POS_PLL +: PLLS]; // R03

  // settings straight from their registers
  assign refSelect = patternRefSel[2:0]; // R10
  assign emphasisOn = {emphasisB[slpt_pkg::POS_EMPH_ON +: 4], emphasisA[slpt_pkg::POS_EMPH_ON +: 4]}; // R12
  assign emphasisKind = {emphasisB[slpt_pkg::POS_KIND +: 4], emphasisA[slpt_pkg::POS_KIND +: 4]}; // R12
  assign dutyFixOn = {emphasisB[slpt_pkg::POS_DUTY +: 4], emphasisA[slpt_pkg::POS_DUTY +: 4]}; // R14
  // level is code/30, zero meaning normal drive
  assign driveLevel = {driveB, driveA}; // R13

  // restart the generator when the length changes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seqSelPrev <= 2'h0;
    end else begin
      seqSelPrev <= patternRefSel[slpt_pkg::POS_SEQ +: 2];
    end
  end

  assign seqRestart = seqSelPrev != patternRefSel[slpt_pkg::POS_SEQ +: 2];

  // one shared generator feeds every lane
  slpt_seq_gen #(
    .WIDTH(31)
  ) u_seq (
    .clk(clk),
    .rst_n(rst_n),
    .seqSel(patternRefSel[slpt_pkg::POS_SEQ +: 2]), // R08
    .restart(seqRestart),
    .seqBit(seqBit)
  );

  // per-lane output stages, test bits skip the line coder
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    slpt_lane_out u_lane (
      .clk(clk),
      .rst_n(rst_n),
      .powerOn(powerNow[i]),
      .testOn(laneTest[i]), // R07 R09
      .flip(laneTest[slpt_pkg::POS_FLIP + i]), // R06
      .seqBit(seqBit),
      .laneIn(laneIn[i]),
      .laneOut(laneOut[i])
    );
  end
endmodule

// ===== design/slpt_seq_gen.sv
/*
 pseudo-random sequence generator, one bit per clock.
 assumes a synchronous restart whenever the length changes.
*/
`timescale 1ns/1ps
module slpt_seq_gen #(
  parameter int WIDTH = 31
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic [1:0] seqSel,
  input wire logic restart,
  // sequence bit
  output logic seqBit
);
  logic [WIDTH-1:0] state;
  logic [WIDTH-1:0] next_state;
  logic feedback;

  // taps of the four maximal-length polynomials
  always_comb begin
    case (slpt_pkg::slpt_seq_t'(seqSel))
      slpt_pkg::SEQ_7: feedback = state[6] ^ state[5];
      slpt_pkg::SEQ_15: feedback = state[14] ^ state[13];
      slpt_pkg::SEQ_23: feedback = state[22] ^ state[17];
      default: feedback = state[30] ^ state[27];
    endcase
    // reseed so a shorter window never starts all zero
    if (restart) begin
      next_state = '1;
    end else begin
      next_state = {state[WIDTH-2:0], feedback};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '1;
      seqBit <= 1'b0;
    end else begin
      state <= next_state;
      seqBit <= feedback;
    end
  end
endmodule

// ===== shared/slpt_pkg.sv
/*
 holds register offsets, field positions, reset values
 and serial frame figures of the lane power/test bank.
 assumes nothing of its surroundings.
*/
package slpt_pkg;
  // register offsets
  localparam logic [6:0] ADDR_PIN_MASK = 7'h1E;
  localparam logic [6:0] ADDR_SW_MASK = 7'h1F;
  localparam logic [6:0] ADDR_LANE_TEST = 7'h20;
  localparam logic [6:0] ADDR_SEL = 7'h21;
  localparam logic [6:0] ADDR_TEMP = 7'h63;
  localparam logic [6:0] ADDR_EMPH_A = 7'h64;
  localparam logic [6:0] ADDR_DRIVE_A = 7'h67;
  localparam logic [6:0] ADDR_EMPH_B = 7'h68;
  localparam logic [6:0] ADDR_DRIVE_B = 7'h6B;
  localparam logic [6:0] ADDR_ALARM = 7'h6C;
  // reset values
  localparam logic [9:0] RST_PIN_MASK = 10'h000;
  localparam logic [15:0] RST_SW_MASK = 16'hFFFF;
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [1:0] RST_ALARM = 2'h3;
  localparam logic [9:0] RST_POWER = 10'h3FF;
  // writable bits
  localparam logic [15:0] WMASK_SEL = 16'h6007;
  localparam logic [15:0] WMASK_EMPH = 16'hFFF0;
  // field positions
  localparam int POS_PLL = 8;
  localparam int POS_FLIP = 8;
  localparam int POS_SEQ = 13;
  localparam int POS_KIND = 12;
  localparam int POS_EMPH_ON = 8;
  localparam int POS_DUTY = 4;
  // serial frame: read flag, 7 address bits, 16 data bits
  localparam logic [4:0] HDR_LAST = 5'h07;
  localparam logic [4:0] FRAME_LAST = 5'h17;
  localparam logic [4:0] DATA_TOP = 5'h17;
  // test sequence codes
  typedef enum logic [1:0] {
    SEQ_31 = 2'b00,
    SEQ_7 = 2'b01,
    SEQ_15 = 2'b10,
    SEQ_23 = 2'b11
  } slpt_seq_t;
endpackage

// ===== testbench/slpt_host.sv
/*
 host model on the serial programming port.
 assumes port levels held two clk cycles each.
*/
`timescale 1ns/1ps
module slpt_host (
  // clock
  input wire logic clk,
  // serial port pins
  output logic portClk,
  output logic portSel_n,
  output logic portDataIn,
  input wire logic portDataOut,
  input wire logic portDataOutEn
);
  initial begin
    portClk = 1'b0;
    portSel_n = 1'b1;
    portDataIn = 1'b0;
  end
  // whole frame: flag, address, word; read bits taken late in low phase
  task automatic xfer(input logic rd, input logic [6:0] a, input logic [15:0] w, output logic [15:0] r);
    logic [23:0] f;
    f = {rd, a, w};
    r = 16'h0000;
    @(negedge clk);
    portSel_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      portDataIn = f[i];
      portClk = 1'b1;
      repeat (2) @(negedge clk);
      portClk = 1'b0;
      repeat (2) @(negedge clk);
      if (i > 0 && i < 17) begin
        r[i-1] = portDataOutEn ? portDataOut : 1'bx;
      end
    end
    portSel_n = 1'b1;
    portDataIn = ~portDataIn; // released line, no stale level
    @(negedge clk);
  endtask
endmodule

// ===== testbench/slpt_regs_props.sv
/*
 port checker of the lane power/test bank.
 assumes binding into slpt_regs, one clock domain.
*/
`timescale 1ns/1ps
module slpt_regs_props #(
  parameter int LANES = 8,
  parameter int PLLS = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // port pins
  input wire logic portClk,
  input wire logic portSel_n,
  input wire logic enablePin,
  input wire logic portDataOut,
  input wire logic portDataOutEn,
  // lane and settings outputs
  input wire logic [LANES-1:0] laneOut,
  input wire logic [LANES-1:0] lanePowerOn,
  input wire logic [PLLS-1:0] pllPowerOn,
  input wire logic [2:0] refSelect,
  input wire logic [LANES-1:0] emphasisOn,
  input wire logic [LANES-1:0] emphasisKind,
  input wire logic [LANES-1:0] dutyFixOn,
  input wire logic [4*LANES-1:0] driveLevel
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [7*LANES+2:0] cfg;
  logic [LANES+PLLS-1:0] pwr;
  logic [3:0] selHist;
  logic [3:0] enHist;
  // bundles so one relation covers every field
  assign cfg = {refSelect, emphasisOn, emphasisKind, dutyFixOn, driveLevel};
  assign pwr = {pllPowerOn, lanePowerOn};
  // recent frame and pin history, the causes of a power change
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      selHist <= 4'h0;
      enHist <= 4'h0;
    end else begin
      selHist <= {selHist[2:0], !portSel_n};
      enHist <= {enHist[2:0], enablePin};
    end
  end
  rst_vals_a: assert property ($rose(rst_n) |-> (&pwr) && cfg == '0)
    else $error("controls not at reset values");
  lane_off_a: assert property ((laneOut & ~lanePowerOn & ~$past(lanePowerOn)) == '0)
    else $error("powered-down lane drives data");
  power_cause_a: assert property ($changed(pwr) |-> (|selHist) || enHist != {4{enHist[0]}})
    else $error("power changed without frame or pin");
  cfg_frame_a: assert property ($changed(cfg) |-> selHist[0])
    else $error("setting changed outside a frame");
  out_idle_a: assert property (portSel_n && $past(portSel_n) |-> !portDataOutEn)
    else $error("data driven while deselected");
  out_sel_a: assert property (portDataOutEn |-> !$past(portSel_n))
    else $error("data driven without select");
  out_step_a: assert property (portDataOutEn && $past(portDataOutEn) && $changed(portDataOut)
    |-> $past(portClk, 2) && !$past(portClk))
    else $error("read bit moved off falling edge");
  en_rise_a: assert property ($rose(portDataOutEn) |-> $past(portClk, 2) && !$past(portClk))
    else $error("driver enabled off falling edge");
  cover property ($fell(|lanePowerOn));
  cover property ($rose(portDataOutEn));
  cover property ($changed(refSelect));
endmodule
bind slpt_regs slpt_regs_props #(.LANES(LANES), .PLLS(PLLS)) i_slpt_regs_props (.*);

// ===== testbench/slpt_regs_tb.sv
/*
 self-checking bench of the lane power/test bank.
 assumes the host model and the bound checker.
*/
`timescale 1ns/1ps
module slpt_regs_tb;
  logic clk, rst_n, enablePin, portClk, portSel_n, portDataIn, portDataOut, portDataOutEn;
  logic [8:0] dieTemp;
  logic [1:0] lockLost, pllPowerOn;
  logic [7:0] laneIn, laneOut, lanePowerOn, emphasisOn, emphasisKind, dutyFixOn;
  logic [2:0] refSelect;
  logic [31:0] driveLevel;
  int n_fail = 0;
  int n_checks = 0;
  int ones;
  logic [6:0] ra [9] = '{7'h1F, 7'h20, 7'h21, 7'h64, 7'h67, 7'h68, 7'h6B, 7'h63, 7'h6C};
  logic [15:0] rv [9] = '{16'hFFFF, 0, 0, 0, 0, 0, 0, 16'h01CE, 16'h0002};
  logic [15:0] wv [9] = '{16'h0, 16'hA55A, 16'hFFFF, 16'hFFFF, 16'h1234, 16'h5A30, 16'hCDEF, 16'hFFFF, 0};
  logic [15:0] ev [9] = '{16'h0, 16'hA55A, 16'h6007, 16'hFFF0, 16'h1234, 16'h5A30, 16'hCDEF, 16'h01CE, 16'h2};
  slpt_regs i_slpt_regs (.clk(clk), .rst_n(rst_n), .portClk(portClk), .portSel_n(portSel_n),
    .portDataIn(portDataIn), .portDataOut(portDataOut), .portDataOutEn(portDataOutEn),
    .enablePin(enablePin), .dieTemp(dieTemp), .lockLost(lockLost), .laneIn(laneIn),
    .laneOut(laneOut), .lanePowerOn(lanePowerOn), .pllPowerOn(pllPowerOn), .refSelect(refSelect),
    .emphasisOn(emphasisOn), .emphasisKind(emphasisKind), .dutyFixOn(dutyFixOn), .driveLevel(driveLevel));
  slpt_host i_slpt_host (.clk(clk), .portClk(portClk), .portSel_n(portSel_n), .portDataIn(portDataIn),
    .portDataOut(portDataOut), .portDataOutEn(portDataOutEn));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [6:0] a, input logic [15:0] e);
    logic [15:0] r;
    i_slpt_host.xfer(1'b1, a, 16'h0000, r);
    chk(r, e);
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] w);
    logic [15:0] r;
    i_slpt_host.xfer(1'b0, a, w, r);
  endtask
  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // 50 ns clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // hang guard
  initial begin
    repeat (99000) @(posedge clk);
    n_fail++;
    end_of_test();
  end
  // test sequence, inputs moved on falling edges
  initial begin
    rst_n = 1'b0;
    enablePin = 1'b1;
    dieTemp = 9'h1CE;
    lockLost = 2'h2;
    laneIn = 8'h0F;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    foreach (ra[i]) rd(ra[i], rv[i]);
    rd(7'h50, 16'h0000);
    $display("reset test done");
    foreach (ra[i]) begin
      wr(ra[i], wv[i]);
      rd(ra[i], ev[i]);
    end
    chk({emphasisOn, emphasisKind, dutyFixOn}, 24'hAF5F3F);
    chk(driveLevel, 32'hCDEF1234);
    for (int c = 0; c < 6; c++) begin
      wr(7'h21, 16'(c));
      chk(refSelect, 32'(c));
    end
    $display("register test done");
    wr(7'h1E, 16'h0300);
    wr(7'h1F, 16'h00F0);
    chk({lanePowerOn, pllPowerOn}, 10'h3C3);
    enablePin = 1'b0;
    repeat (3) @(negedge clk);
    chk({lanePowerOn, pllPowerOn}, 10'h003);
    chk(laneOut, 8'h00);
    wr(7'h1E, 16'hFC81);
    rd(7'h1E, 16'h0081);
    chk({lanePowerOn, pllPowerOn}, 10'h204);
    enablePin = 1'b1;
    wr(7'h1F, 16'hFFFF);
    chk({lanePowerOn, pllPowerOn}, 10'h3FF);
    $display("power test done");
    wr(7'h20, 16'hFF00);
    chk(laneOut, 8'hF0);
    wr(7'h20, 16'h80C0);
    for (int c = 0; c < 4; c++) begin
      wr(7'h21, 16'(c << 13));
      repeat (2) @(negedge clk);
      chk({laneOut[7] ^ laneOut[6], laneOut[5:0]}, 7'h4F);
    end
    for (int c = 1; c < 3; c++) begin
      wr(7'h21, 16'(c << 13));
      repeat (3) @(negedge clk);
      ones = 0;
      for (int k = 0; k < ((c == 1) ? 254 : 65534); k++) begin
        ones += int'(laneOut[6] === 1'b1);
        laneIn = ~laneIn;
        @(negedge clk);
      end
      chk(32'(ones), (c == 1) ? 32'd128 : 32'd32768);
    end
    $display("lane test done");
    // reset in mid-run, outside any frame
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    chk({laneOut, lanePowerOn, pllPowerOn}, 18'h003FF);
    rst_n = 1'b1;
    rd(7'h1E, 16'h0000);
    rd(7'h20, 16'h0000);
    chk({refSelect, lanePowerOn, pllPowerOn}, 13'h03FF);
    $display("mid-run reset test done");
    end_of_test();
  end
endmodule
